// ---- verilog/rtc_defs.vh ----
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

// Register byte offsets on the APB bus.
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_TRIM        8'h08
`define OFS_CAL_SEC     8'h0c
`define OFS_CAL_MIN     8'h10
`define OFS_CAL_HOUR    8'h14
`define OFS_CAL_DAY     8'h18
`define OFS_CAL_MONTH   8'h1c
`define OFS_CAL_YEAR    8'h20
`define OFS_ALM_SEC     8'h24
`define OFS_ALM_MIN     8'h28
`define OFS_ALM_HOUR    8'h2c
`define OFS_ALM_DAY     8'h30
`define OFS_ALM_MONTH   8'h34
`define OFS_ALM_YEAR    8'h38
`define OFS_SECS_0      8'h3c
`define OFS_SECS_1      8'h40
`define OFS_SECS_2      8'h44
`define OFS_SECS_3      8'h48

// Control register fields.
`define CTRL_CRYSTAL    0
`define CTRL_KEEP_ALIVE 1
`define CTRL_ALARM_ON   2
`define CTRL_TICK_ON    3
`define CTRL_TICK_MIN   4
`define CTRL_TICK_WAKE  5
`define CTRL_MONITOR    6
`define CTRL_GATE_SEL   7

// Status register fields.
`define STAT_VALID      0
`define STAT_ALARM      1
`define STAT_TICK       2
`define STAT_STABLE     3

// Reset values.
`define CTRL_RESET      8'h03
`define TRIM_RESET      8'h00
`define DAY_RESET       5'h01
`define MONTH_RESET     4'h1

// Counts in 32 kHz periods.
`define SECOND_PERIODS  17'h08000
`define STAB_PERIODS    16'h4000
`define VALID_PERIODS   8'h40

`endif

// ---- verilog/rtc_calendar_alarm_32k.v ----
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "rtc_defs.vh"

module rtc_calendar_alarm_32k (
    // Clock and reset
    input  wire        clock,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // 32 kHz sources
    input  wire        xtal_osc_in,
    input  wire        xtal_out_pin,
    // Power manager
    input  wire        active_mode,
    input  wire        power_down_mode,
    input  wire        seq_has_osc_enable_slot,
    input  wire        clock_out_hold,
    // Clock output and sequencer answer
    output reg         clock_out_pin,
    output reg         osc_start_ready,
    // Events
    output reg         alarm_irq,
    output reg         wake_up
);

    reg        rst_meta, rst_n_s;
    reg [7:0]  ctrl, calendar_trim, valid_cnt;
    reg        tick_min_act, tick_wake_act;
    reg [5:0]  sec, min, year;
    reg [4:0]  hour, day, month_days;
    reg [3:0]  month;
    reg [5:0]  l_min, l_year;
    reg [4:0]  l_hour, l_day;
    reg [3:0]  l_month;
    reg [5:0]  a_sec, a_min, a_year;
    reg [4:0]  a_hour, a_day;
    reg [3:0]  a_month;
    reg [31:0] secs, l_secs, next_prdata;
    reg [16:0] pre;
    reg [3:0]  group;
    reg        src_q, src_q2, stab_done;
    reg [15:0] stab_cnt;
    reg        cal_valid, alarm_event, tick_event;
    reg        provided_once, sec_pulse, check, next_err;

    wire crystal    = ctrl[`CTRL_CRYSTAL];
    wire keep_alive = ctrl[`CTRL_KEEP_ALIVE];
    wire monitor    = ctrl[`CTRL_MONITOR];
    wire edge32     = src_q & ~src_q2;
    wire rtc_edge   = edge32 & keep_alive;
    wire wr         = psel & penable & pready & pwrite;
    wire rd         = psel & penable & pready & ~pwrite;
    wire [16:0] trim_ext   = {{9{calendar_trim[7]}}, calendar_trim};
    wire [16:0] second_len = (group == 4'h0) ? (`SECOND_PERIODS - trim_ext) : `SECOND_PERIODS;
    wire        last_sec   = (sec == 6'h3b);
    wire        last_min   = (min == 6'h3b);
    wire        last_hour  = (hour == 5'h17);
    wire        last_day   = (day == month_days);
    wire        last_month = (month == 4'hc);
    wire        alarm_hit  = (sec == a_sec) && (min == a_min) && (hour == a_hour) &&
                             (day == a_day) && (month == a_month) && (year == a_year);
    // Match is checked one cycle after the second update so the new time is compared.
    wire        tick_now   = check & (~tick_min_act | (sec == 6'h00));
    wire        hold_gate  = (~seq_has_osc_enable_slot | provided_once) & clock_out_hold;
    wire        stab_gate  = crystal & ctrl[`CTRL_GATE_SEL] & ~stab_done;
    wire        set_alarm  = check & ctrl[`CTRL_ALARM_ON] & alarm_hit;
    wire        set_tick   = tick_now & ctrl[`CTRL_TICK_ON];

    always @* begin
        case (month)
            4'h2:    month_days = (year[1:0] == 2'b00) ? 5'd29 : 5'd28;
            4'h4, 4'h6, 4'h9, 4'hb: month_days = 5'd30;
            default: month_days = 5'd31;
        endcase
    end

    // Reset is released through two flip-flops.
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n_s  <= rst_meta;
        end
    end

    always @* begin
        next_prdata = 32'h00000000;
        next_err    = 1'b0;
        case (paddr)
            `OFS_CTRL:      next_prdata = {24'h000000, ctrl};
            `OFS_STATUS:    next_prdata = {28'h0000000, stab_done, tick_event, alarm_event, cal_valid};
            `OFS_TRIM:      next_prdata = {24'h000000, calendar_trim};
            `OFS_CAL_SEC:   next_prdata = {26'h0000000, sec};
            `OFS_CAL_MIN:   next_prdata = {26'h0000000, l_min};
            `OFS_CAL_HOUR:  next_prdata = {27'h0000000, l_hour};
            `OFS_CAL_DAY:   next_prdata = {27'h0000000, l_day};
            `OFS_CAL_MONTH: next_prdata = {28'h0000000, l_month};
            `OFS_CAL_YEAR:  next_prdata = {26'h0000000, l_year};
            `OFS_ALM_SEC:   next_prdata = {26'h0000000, a_sec};
            `OFS_ALM_MIN:   next_prdata = {26'h0000000, a_min};
            `OFS_ALM_HOUR:  next_prdata = {27'h0000000, a_hour};
            `OFS_ALM_DAY:   next_prdata = {27'h0000000, a_day};
            `OFS_ALM_MONTH: next_prdata = {28'h0000000, a_month};
            `OFS_ALM_YEAR:  next_prdata = {26'h0000000, a_year};
            `OFS_SECS_0:    next_prdata = {24'h000000, secs[7:0]};
            `OFS_SECS_1:    next_prdata = {24'h000000, l_secs[15:8]};
            `OFS_SECS_2:    next_prdata = {24'h000000, l_secs[23:16]};
            `OFS_SECS_3:    next_prdata = {24'h000000, l_secs[31:24]};
            default:        next_err    = 1'b1;
        endcase
    end

    // One wait state: the answer is prepared, then pready rises for one cycle.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata  <= pwrite ? 32'h00000000 : next_prdata;
            pslverr <= next_err;
            pready  <= 1'b1;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Source selection, edge detection and stabilization timer.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            src_q     <= 1'b0;
            src_q2    <= 1'b0;
            stab_cnt  <= 16'h0000;
            stab_done <= 1'b0;
        end else begin
            src_q  <= crystal ? xtal_osc_in : xtal_out_pin;
            src_q2 <= src_q;
            if (!crystal) begin
                stab_cnt  <= 16'h0000;
                stab_done <= 1'b0;
            end else if (edge32 && !stab_done) begin
                stab_cnt  <= stab_cnt + 16'h0001;
                stab_done <= (stab_cnt == `STAB_PERIODS - 16'h0001);
            end
        end
    end

    // Pin and sequencer outputs.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            clock_out_pin   <= 1'b0;
            osc_start_ready <= 1'b0;
            provided_once   <= 1'b0;
        end else begin
            clock_out_pin   <= active_mode & ~hold_gate & ~stab_gate & src_q2;
            osc_start_ready <= ~crystal | stab_done;
            provided_once   <= provided_once | clock_out_pin;
        end
    end

    // Control, trim and alarm registers.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl          <= `CTRL_RESET;
            calendar_trim <= `TRIM_RESET;
            tick_min_act  <= 1'b0;
            tick_wake_act <= 1'b0;
            a_sec         <= 6'h00;
            a_min         <= 6'h00;
            a_hour        <= 5'h00;
            a_day         <= `DAY_RESET;
            a_month       <= `MONTH_RESET;
            a_year        <= 6'h00;
        end else if (wr) begin
            case (paddr)
                `OFS_CTRL: begin
                    if (!monitor)
                        ctrl[1:0] <= pwdata[1:0];
                    ctrl[7:2] <= pwdata[7:2];
                end
                `OFS_TRIM:      calendar_trim <= pwdata[7:0];
                `OFS_ALM_SEC:   a_sec   <= pwdata[5:0];
                `OFS_ALM_MIN:   a_min   <= pwdata[5:0];
                `OFS_ALM_HOUR:  a_hour  <= pwdata[4:0];
                `OFS_ALM_DAY:   a_day   <= pwdata[4:0];
                `OFS_ALM_MONTH: a_month <= pwdata[3:0];
                `OFS_ALM_YEAR: begin
                    a_year        <= pwdata[5:0];
                    tick_min_act  <= ctrl[`CTRL_TICK_MIN];
                    tick_wake_act <= ctrl[`CTRL_TICK_WAKE];
                end
                default: ;
            endcase
        end
    end

    // Prescaler, calendar and seconds counter.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pre       <= 17'h00000;
            group     <= 4'h0;
            sec_pulse <= 1'b0;
            sec       <= 6'h00;
            min       <= 6'h00;
            hour      <= 5'h00;
            day       <= `DAY_RESET;
            month     <= `MONTH_RESET;
            year      <= 6'h00;
            secs      <= 32'h00000000;
        end else begin
            sec_pulse <= 1'b0;
            if (rtc_edge) begin
                if (pre >= second_len - 17'h00001) begin
                    pre       <= 17'h00000;
                    group     <= group + 4'h1;
                    sec_pulse <= 1'b1;
                end else begin
                    pre <= pre + 17'h00001;
                end
            end
            if (sec_pulse) begin
                secs <= secs + 32'h00000001;
                sec <= last_sec ? 6'h00 : sec + 6'h01;
                if (last_sec) begin
                    min <= last_min ? 6'h00 : min + 6'h01;
                    if (last_min) begin
                        hour <= last_hour ? 5'h00 : hour + 5'h01;
                        if (last_hour) begin
                            day <= last_day ? `DAY_RESET : day + 5'h01;
                            if (last_day) begin
                                month <= last_month ? `MONTH_RESET : month + 4'h1;
                                if (last_month)
                                    year <= year + 6'h01;
                            end
                        end
                    end
                end
            end
            // Host setting of time wins over a concurrent count.
            if (wr) begin
                case (paddr)
                    `OFS_CAL_SEC: begin
                        sec <= pwdata[5:0];
                        pre <= 17'h00000;
                    end
                    `OFS_CAL_MIN:   min   <= pwdata[5:0];
                    `OFS_CAL_HOUR:  hour  <= pwdata[4:0];
                    `OFS_CAL_DAY:   day   <= pwdata[4:0];
                    `OFS_CAL_MONTH: month <= pwdata[3:0];
                    `OFS_CAL_YEAR:  year  <= pwdata[5:0];
                    default: ;
                endcase
            end
        end
    end

    // Coherent read latches.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            l_min   <= 6'h00;
            l_hour  <= 5'h00;
            l_day   <= `DAY_RESET;
            l_month <= `MONTH_RESET;
            l_year  <= 6'h00;
            l_secs  <= 32'h00000000;
        end else if (rd) begin
            if (paddr == `OFS_CAL_SEC) begin
                l_min   <= min;
                l_hour  <= hour;
                l_day   <= day;
                l_month <= month;
                l_year  <= year;
            end
            if (paddr == `OFS_SECS_0)
                l_secs <= secs;
        end
    end

    // Calendar-valid timer and events.
    always @(posedge clock or negedge rst_n_s) begin
        if (!rst_n_s) begin
            valid_cnt   <= 8'h00;
            cal_valid   <= 1'b0;
            check       <= 1'b0;
            alarm_event <= 1'b0;
            tick_event  <= 1'b0;
            alarm_irq   <= 1'b0;
            wake_up     <= 1'b0;
        end else begin
            if (rtc_edge && !cal_valid) begin
                valid_cnt <= valid_cnt + 8'h01;
                cal_valid <= (valid_cnt == `VALID_PERIODS - 8'h01);
            end
            check <= sec_pulse;
            if (wr && paddr == `OFS_STATUS) begin
                if (pwdata[`STAT_ALARM])
                    alarm_event <= 1'b0;
                if (pwdata[`STAT_TICK])
                    tick_event <= 1'b0;
            end
            if (set_alarm)
                alarm_event <= 1'b1;
            if (set_tick)
                tick_event <= 1'b1;
            alarm_irq <= alarm_event | tick_event | set_alarm | set_tick;
            wake_up   <= power_down_mode & (set_alarm | (set_tick & tick_wake_act));
        end
    end

endmodule

// ---- tb/clk32k_source.sv ----
`timescale 1ns/1ps
// The crystal has a three-cycle period at two-thirds duty and the external clock a
// two-cycle period, so the clock output can tell which one is routed to it.
// The external clock is the faster one so that a counted second stays short.
module clk32k_source (
    // System clock
    input  wire logic clock,
    // Sources
    output wire logic osc,
    output wire logic ext
);
    logic [1:0] phase = 2'd0;
    logic       ext_q = 1'b0;

    always @(posedge clock) begin
        phase <= (phase == 2'd2) ? 2'd0 : phase + 2'd1;
        ext_q <= ~ext_q;
    end

    assign osc = (phase != 2'd2);
    assign ext = ext_q;
endmodule

// ---- tb/rtc_calendar_alarm_32k_sva.sv ----
`timescale 1ns/1ps
module rtc_calendar_alarm_32k_sva (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rstn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Clocks and power
    input wire logic        xtal_osc_in,
    input wire logic        xtal_out_pin,
    input wire logic        active_mode,
    input wire logic        power_down_mode,
    input wire logic        seq_has_osc_enable_slot,
    input wire logic        clock_out_hold,
    input wire logic        clock_out_pin,
    input wire logic        osc_start_ready,
    // Events
    input wire logic        alarm_irq,
    input wire logic        wake_up
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    wire logic clr_wr;
    assign clr_wr = psel && penable && pready && pwrite && (paddr == 8'h04);

    ready_pulse_a: assert property (pready |=> !pready) else $error("pready wider than one cycle");
    ready_wait_a: assert property ($rose(penable) && psel |-> !pready ##1 pready) else $error("pready delay wrong");
    ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    unmapped_err_a: assert property (pready && paddr > 8'h48 |-> pslverr) else $error("unmapped not refused");
    mapped_ok_a: assert property (pready && paddr <= 8'h48 && paddr[1:0] == 2'b00 |-> !pslverr)
        else $error("mapped access refused");
    err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read not 0");
    hold_gate_a: assert property ((clock_out_hold && !seq_has_osc_enable_slot)[*3] |-> !clock_out_pin)
        else $error("clock output not held");
    idle_gate_a: assert property ((!active_mode)[*3] |-> !clock_out_pin)
        else $error("clock output on outside active mode");
    wake_pulse_a: assert property (wake_up |=> !wake_up) else $error("wake wider than one cycle");
    wake_mode_a: assert property (wake_up |-> $past(power_down_mode)) else $error("wake outside power-down");
    wake_irq_a: assert property ($rose(wake_up) |-> ##[0:2] alarm_irq) else $error("wake without event");
    irq_hold_a: assert property (alarm_irq && !clr_wr && !$past(clr_wr) |=> alarm_irq)
        else $error("event dropped without clear");

    cover property (pready && pslverr);
    cover property (wake_up);
    cover property ($rose(alarm_irq));
    cover property ($rose(clock_out_pin) && active_mode);
endmodule

bind rtc_calendar_alarm_32k rtc_calendar_alarm_32k_sva rtc_calendar_alarm_32k_sva_i (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .xtal_osc_in, .xtal_out_pin, .active_mode, .power_down_mode, .seq_has_osc_enable_slot,
    .clock_out_hold, .clock_out_pin, .osc_start_ready, .alarm_irq, .wake_up
);

// ---- tb/rtc_calendar_alarm_32k_test.sv ----
`timescale 1ns/1ps
module rtc_calendar_alarm_32k_test;
    reg         clock = 1'b0;
    reg         rstn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    reg         active_mode;
    reg         power_down_mode;
    reg         seq_has_osc_enable_slot;
    reg         clock_out_hold;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire        xtal_osc_in;
    wire        xtal_out_pin;
    wire        clock_out_pin;
    wire        osc_start_ready;
    wire        alarm_irq;
    wire        wake_up;
    integer     miscompares = 0;
    integer     num_checks = 0;
    integer     i;
    integer     n;
    reg  [31:0] q;
    reg         e;
    reg  [31:0] wakes;

    always #12.5 clock = ~clock;

    clk32k_source clk32k_source_i (.clock, .osc(xtal_osc_in), .ext(xtal_out_pin));

    rtc_calendar_alarm_32k rtc_calendar_alarm_32k_i (
        .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .xtal_osc_in, .xtal_out_pin, .active_mode, .power_down_mode, .seq_has_osc_enable_slot,
        .clock_out_hold, .clock_out_pin, .osc_start_ready, .alarm_irq, .wake_up
    );

    task stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task check(input [31:0] seen, input [31:0] want);
        num_checks = num_checks + 1;
        if (seen !== want) begin
            miscompares = miscompares + 1;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, want);
        end
    endtask

    // The request is held until pready is seen high at a rising edge.
    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        @(posedge clock);
        while (pready !== 1'b1 && k < 20) begin
            @(posedge clock);
            k = k + 1;
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k == 20) begin
            miscompares = miscompares + 1;
            stop_test;
        end
    endtask

    task wr(input [7:0] a, input [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input [7:0] a, input [31:0] want);
        apb(1'b0, a, 32'h0);
        check(q, want);
    endtask

    // Twelve cycles hold whole periods of both sources: crystal gives 8 highs, external 6, gated 0.
    task highs(input [31:0] want);
        reg [31:0] c;
        repeat (4) @(posedge clock);
        c = 0;
        repeat (12) begin
            @(posedge clock);
            c = c + clock_out_pin;
        end
        check(c, want);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        active_mode = 1'b1;
        power_down_mode = 1'b0;
        seq_has_osc_enable_slot = 1'b0;
        clock_out_hold = 1'b0;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(8'h00, 32'h03);
        wr(8'h00, 32'h02);
        n = 0;
        q = 32'h0;
        while (q[0] !== 1'b1 && n < 300) begin
            apb(1'b0, 8'h04, 32'h0);
            n = n + 1;
        end
        check(q[0], 1'b1);
        for (i = 3; i < 19; i = i + 1) begin
            if (i < 9 || i > 14) begin
                rd(8'(4 * i), (i == 6 || i == 7) ? 32'h1 : 32'h0);
            end
        end
        $display("reset test done");
        rd(8'h4c, 32'h0);
        check(e, 1'b1);
        wr(8'h80, 32'hff);
        check(e, 1'b1);
        wr(8'h08, 32'h7f);
        rd(8'h08, 32'h7f);
        wr(8'h08, 32'h81);
        rd(8'h08, 32'h81);
        $display("bus test done");
        check(osc_start_ready, 1'b1);
        highs(6);
        @(posedge clock) clock_out_hold <= 1'b1;
        highs(0);
        // After the first provision the hold applies even with the oscillator-enable slot.
        @(posedge clock) seq_has_osc_enable_slot <= 1'b1;
        highs(0);
        @(posedge clock) clock_out_hold <= 1'b0;
        @(posedge clock) active_mode <= 1'b0;
        highs(0);
        @(posedge clock) active_mode <= 1'b1;
        wr(8'h00, 32'h01);
        highs(8);
        wr(8'h08, 32'h00);
        wr(8'h00, 32'h82);
        wr(8'h00, 32'h83);
        highs(0);
        check(osc_start_ready, 1'b0);
        wr(8'h00, 32'h02);
        highs(6);
        $display("clock output test done");
        wr(8'h0c, 32'h0);
        // Year goes last so that the tick settings are taken up.
        for (i = 0; i < 6; i = i + 1) begin
            wr(8'(8'h24 + 4 * i), (i == 0 || i == 3 || i == 4) ? 32'h1 : 32'h0);
        end
        // Per-minute ticks are chosen here but stay inactive until the next alarm year write.
        wr(8'h00, 32'h5e);
        wr(8'h00, 32'h5d);
        rd(8'h00, 32'h5e);
        @(posedge clock) power_down_mode <= 1'b1;
        n = 0;
        wakes = 0;
        while (alarm_irq !== 1'b1 && n < 100000) begin
            @(posedge clock);
            wakes = wakes + (wake_up === 1'b1);
            n = n + 1;
        end
        check(alarm_irq, 1'b1);
        if (n == 100000) begin
            stop_test;
        end
        repeat (4) begin
            @(posedge clock);
            wakes = wakes + (wake_up === 1'b1);
        end
        check(wakes, 1);
        apb(1'b0, 8'h04, 32'h0);
        check(q & 32'h7, 32'h7);
        rd(8'h0c, 32'h1);
        rd(8'h10, 32'h0);
        rd(8'h3c, 32'h1);
        rd(8'h40, 32'h0);
        wr(8'h04, 32'h06);
        apb(1'b0, 8'h04, 32'h0);
        check(q & 32'h6, 32'h0);
        check(alarm_irq, 1'b0);
        $display("alarm test done");
        stop_test;
    end
endmodule
